// >>> logic/vtpst_pkg.sv
// shared constants for the video test pattern and self-check link
package vtpst_pkg;
  localparam int VTPST_DATA_W = 10;
  localparam int VTPST_CODE_W = 4;
  localparam int VTPST_CNT_W  = 8;
  localparam int VTPST_CRC_W  = 16;
  localparam int VTPST_SCR_W  = 9;
  localparam int VTPST_SCR_TAP_HI = 8;
  localparam int VTPST_SCR_TAP_LO = 3;
  // selection code field positions
  localparam int VTPST_CODE_WIDE = 3;
  localparam int VTPST_CODE_PAL  = 2;
  // serial bits per parallel word
  localparam logic [3:0] VTPST_WORD_BITS = 4'hA;
  localparam logic [7:0] VTPST_BIT_RATIO = 8'h0A;
  // loop model and self-check timing; only the first two in system clock cycles
  localparam logic [7:0] VTPST_LOST_CYCLES  = 8'hFF;
  localparam logic [7:0] VTPST_MIN_PERIOD   = 8'h0A;
  localparam logic [2:0] VTPST_LOCK_PERIODS = 3'h4;
  localparam logic [1:0] VTPST_CHECK_SKIP   = 2'h2;
  localparam logic [1:0] VTPST_CHECK_FIELDS = 2'h2;
  // pattern selects in code bits 1:0
  localparam logic [1:0] VTPST_PAT_BLACK = 2'h0;
  localparam logic [1:0] VTPST_PAT_LOOP  = 2'h1;
  localparam logic [1:0] VTPST_PAT_EQ    = 2'h2;
  localparam logic [1:0] VTPST_PAT_BARS  = 2'h3;
  // codes that also run the self-check
  localparam logic [3:0] VTPST_CHECK_NTSC = 4'h3;
  localparam logic [3:0] VTPST_CHECK_PAL  = 4'h5;
  // component word values
  localparam logic [9:0] VTPST_CHROMA_BLACK = 10'h200;
  localparam logic [9:0] VTPST_LUMA_BLACK   = 10'h040;
  localparam logic [9:0] VTPST_CHROMA_LOOP  = 10'h200;
  localparam logic [9:0] VTPST_LUMA_LOOP    = 10'h110;
  localparam logic [9:0] VTPST_CHROMA_EQ    = 10'h300;
  localparam logic [9:0] VTPST_LUMA_EQ      = 10'h198;
  // bars {luma, cb, cr}, index 0 is the leftmost bar
  localparam logic [7:0][29:0] VTPST_BARS = {
    {10'h040, 10'h200, 10'h200}, {10'h08C, 10'h350, 10'h1C8},
    {10'h104, 10'h190, 10'h350}, {10'h150, 10'h2E0, 10'h318},
    {10'h1C0, 10'h120, 10'h0E8}, {10'h20C, 10'h270, 10'h0B0},
    {10'h288, 10'h0B0, 10'h238}, {10'h2D0, 10'h200, 10'h200}};
  localparam logic [15:0] VTPST_CRC_POLY  = 16'h1041;
  localparam logic [15:0] VTPST_CRC_RESET = 16'h0000;
  // controller
  localparam int VTPST_CLK_MHZ     = 50;
  localparam int VTPST_POWER_UP_US = 30;
  localparam int VTPST_POWER_UP_CYCLES = VTPST_POWER_UP_US * VTPST_CLK_MHZ;
  localparam int VTPST_PU_W = $clog2(VTPST_POWER_UP_CYCLES + 1);
  localparam logic [11:0] VTPST_REG_CTRL   = 12'h000;
  localparam logic [11:0] VTPST_REG_DIV    = 12'h004;
  localparam logic [11:0] VTPST_REG_STATUS = 12'h008;
  localparam int VTPST_CTRL_RUN  = 0;
  localparam int VTPST_CTRL_MRST = 1;
  localparam int VTPST_CTRL_CODE = 4;
  localparam logic [7:0] VTPST_DIV_RESET = 8'h0A;
  localparam logic [7:0] VTPST_DIV_MIN   = 8'h05;
endpackage

// >>> logic/vtpst_link_if.sv
// parallel-side link between the serializer and its controller
`timescale 1ns/1ps
`default_nettype none
interface vtpst_link_if;
  logic       parClk;
  logic [9:0] patternCode;
  logic       patternGenEnable;
  logic       manualReset;
  logic       lockDetect;
  logic       selfCheckResult;
  logic       serialLineOut;
  logic       serialLineOutN;
  logic       serialLineOe;
  modport dev (
    input  parClk, patternCode, patternGenEnable, manualReset,
    output lockDetect, selfCheckResult,
    output serialLineOut, serialLineOutN, serialLineOe
  );
  modport ctl (
    output parClk, patternCode, patternGenEnable, manualReset,
    input  lockDetect, selfCheckResult,
    input  serialLineOut, serialLineOutN, serialLineOe
  );
endinterface // vtpst_link_if
`default_nettype wire

// >>> logic/vtpst_device.sv
// serializer end: reset, loop model, pattern generator and self-check
// Summary of operation
// - serial output holds still while unlocked
// - reset clears state, check words, output
// - power-on reset floats both serial outputs
// - stay in reset until parallel clock seen
// - manual reset high resets logic and loop
// - controller delays clock 30 us after power
// - self-check sends pattern, checks it back
// - self-check needs code, zero high bits, clock
// - controller enables only after lock is high
// - pass goes high after two clean fields
// - any error keeps result low until exit
// - serial output continues during self-check
// - four patterns, both standards, both rasters
// - colour bars switch abruptly, no filtering
// - pattern needs code, clock, lock before enable
// - enable high shows pattern, low leaves
// - code bits pick raster, standard, pattern
// - self-check only for two specific codes
// - lock high when locked, drops on loss
// - bit rate ten times the parallel clock
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module vtpst_device
  import vtpst_pkg::*;
#(
  parameter int NTSC_LINE_WORDS      = 1716,
  parameter int PAL_LINE_WORDS       = 1728,
  parameter int NTSC_WIDE_LINE_WORDS = 2288,
  parameter int PAL_WIDE_LINE_WORDS  = 2304,
  parameter int NTSC_FIELD_LINES     = 262,
  parameter int PAL_FIELD_LINES      = 312
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   cke,
  vtpst_link_if.dev                   link,
  output logic      [VTPST_CRC_W-1:0] checkWords_q,
  output logic                        patternActive_q
);
  localparam int PIN_N = VTPST_DATA_W + 3;

  if (NTSC_LINE_WORDS < 16 || NTSC_LINE_WORDS > 4095 ||
      PAL_LINE_WORDS < 16 || PAL_LINE_WORDS > 4095 ||
      NTSC_WIDE_LINE_WORDS < 16 || NTSC_WIDE_LINE_WORDS > 4095 ||
      PAL_WIDE_LINE_WORDS < 16 || PAL_WIDE_LINE_WORDS > 4095 ||
      NTSC_FIELD_LINES < 1 || NTSC_FIELD_LINES > 1023 ||
      PAL_FIELD_LINES < 1 || PAL_FIELD_LINES > 1023) begin : g_bad
    $error("vtpst_device: raster parameter out of range");
  end

  logic [PIN_N-1:0]        pinRaw;
  logic [PIN_N-1:0]        pinQ;
  logic                    manualRst;
  logic                    enPin;
  logic                    parClkLvl;
  logic [VTPST_DATA_W-1:0] dataIn;
  logic                    parClkPrev_q;
  logic                    parRise;
  logic                    logicRst;
  logic                    coreRst;
  logic                    clockSeen_q;
  logic [VTPST_CNT_W-1:0]  periodCnt_q;
  logic [VTPST_CNT_W-1:0]  period_q;
  logic [2:0]              stable_q;
  logic                    lock_q;
  logic                    periodOk;
  logic                    enWord_q;
  logic                    checkMode_q;
  logic [VTPST_CODE_W-1:0] code_q;
  logic                    startWord;
  logic [11:0]             lineWords;
  logic [11:0]             barWords;
  logic [9:0]              fieldLines;
  logic [11:0]             wordCnt_q;
  logic [11:0]             barPos_q;
  logic [9:0]              lineCnt_q;
  logic [2:0]              barIdx_q;
  logic [1:0]              fieldCnt_q;
  logic [29:0]             barEntry;
  logic [9:0]              patWord;
  logic [9:0]              txWord;
  logic [VTPST_CNT_W-1:0]  bitDiv;
  logic [VTPST_CNT_W-1:0]  bitTimer_q;
  logic [3:0]              bitCnt_q;
  logic [9:0]              shift_q;
  logic [9:0]              sentWord_q;
  logic [VTPST_SCR_W-1:0]  scr_q;
  logic                    emit;
  logic                    txBit;
  logic                    scrBit;
  logic                    lineBit;
  logic                    serialOut_q;
  logic                    serialOutN_q;
  logic                    serialOe_q;
  logic                    emitted_q;
  logic                    rxPrev_q;
  logic [VTPST_SCR_W-1:0]  rxScr_q;
  logic [9:0]              rxShift_q;
  logic [3:0]              rxCnt_q;
  logic [1:0]              skip_q;
  logic                    rxS;
  logic                    rxD;
  logic [9:0]              rxWord;
  logic                    errNow;
  logic                    error_q;
  logic                    result_q;

  // every pin passes four flops; a change counts once stages 2 and 3 agree
  assign pinRaw = {link.manualReset, link.patternGenEnable, link.parClk,
                   link.patternCode};
  for (genvar i = 0; i < PIN_N; i++) begin : g_sync
    logic s1;
    logic s2;
    logic s3;
    logic q;
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        q  <= 1'b0;
      end else if (cke) begin
        s1 <= pinRaw[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) q <= s3;
      end
    end
    assign pinQ[i] = q;
  end

  assign manualRst = pinQ[PIN_N-1];
  assign enPin     = pinQ[PIN_N-2];
  assign parClkLvl = pinQ[PIN_N-3];
  assign dataIn    = pinQ[VTPST_DATA_W-1:0];
  assign parRise   = parClkLvl & ~parClkPrev_q;
  assign logicRst  = sys_rst | manualRst;
  assign coreRst   = logicRst | ~clockSeen_q;

  always_ff @(posedge clk) begin
    if (sys_rst) parClkPrev_q <= 1'b0;
    else if (cke) parClkPrev_q <= parClkLvl;
  end

  always_ff @(posedge clk) begin
    if (logicRst) clockSeen_q <= 1'b0;
    else if (cke && parRise) clockSeen_q <= 1'b1;
  end

  // loop model: lock after steady periods, lost on a long gap
  assign periodOk = (periodCnt_q >= VTPST_MIN_PERIOD) &&
                    (periodCnt_q == period_q);
  always_ff @(posedge clk) begin
    if (logicRst) begin
      periodCnt_q <= '0;
      period_q    <= '0;
      stable_q    <= '0;
      lock_q      <= 1'b0;
    end else if (cke) begin
      if (parRise) begin
        periodCnt_q <= 8'h01;
        period_q    <= periodCnt_q;
        if (!periodOk) stable_q <= '0;
        else if (stable_q != VTPST_LOCK_PERIODS) stable_q <= stable_q + 3'h1;
        lock_q <= periodOk && (stable_q == VTPST_LOCK_PERIODS);
      end else if (periodCnt_q == VTPST_LOST_CYCLES) begin
        stable_q <= '0;
        lock_q   <= 1'b0;
      end else begin
        periodCnt_q <= periodCnt_q + 8'h01;
      end
    end
  end

  // mode latch on a word boundary
  assign startWord = parRise && enPin && !enWord_q;
  always_ff @(posedge clk) begin
    if (coreRst) begin
      enWord_q        <= 1'b0;
      patternActive_q <= 1'b0;
      checkMode_q     <= 1'b0;
      code_q          <= '0;
    end else if (cke) begin
      // leaving needs no word edge: the parallel clock may already be gone
      if (!enPin) begin
        enWord_q        <= 1'b0;
        patternActive_q <= 1'b0;
        checkMode_q     <= 1'b0;
      end else if (startWord) begin
        enWord_q        <= 1'b1;
        code_q          <= dataIn[VTPST_CODE_W-1:0];
        patternActive_q <= 1'b1;
        checkMode_q     <= (dataIn[VTPST_CODE_W-1:0] == VTPST_CHECK_NTSC) ||
                           (dataIn[VTPST_CODE_W-1:0] == VTPST_CHECK_PAL);
      end
    end
  end

  always_comb begin
    case ({code_q[VTPST_CODE_WIDE], code_q[VTPST_CODE_PAL]})
      2'b00:   lineWords = 12'(NTSC_LINE_WORDS);
      2'b01:   lineWords = 12'(PAL_LINE_WORDS);
      2'b10:   lineWords = 12'(NTSC_WIDE_LINE_WORDS);
      default: lineWords = 12'(PAL_WIDE_LINE_WORDS);
    endcase
  end
  assign fieldLines = code_q[VTPST_CODE_PAL] ? 10'(PAL_FIELD_LINES) :
                                               10'(NTSC_FIELD_LINES);
  assign barWords = {3'h0, lineWords[11:3]};

  always_ff @(posedge clk) begin
    if (coreRst || (cke && parRise && !patternActive_q)) begin
      wordCnt_q  <= '0;
      barPos_q   <= '0;
      barIdx_q   <= '0;
      lineCnt_q  <= '0;
      fieldCnt_q <= '0;
    end else if (cke && parRise) begin
      if (wordCnt_q == lineWords - 12'h001) begin
        wordCnt_q <= '0;
        barPos_q  <= '0;
        barIdx_q  <= '0;
        if (lineCnt_q == fieldLines - 10'h001) begin
          lineCnt_q <= '0;
          if (fieldCnt_q != VTPST_CHECK_FIELDS) fieldCnt_q <= fieldCnt_q + 2'h1;
        end else begin
          lineCnt_q <= lineCnt_q + 10'h001;
        end
      end else begin
        wordCnt_q <= wordCnt_q + 12'h001;
        if (barPos_q == barWords - 12'h001) begin
          barPos_q <= '0;
          if (barIdx_q != 3'h7) barIdx_q <= barIdx_q + 3'h1;
        end else begin
          barPos_q <= barPos_q + 12'h001;
        end
      end
    end
  end

  // word order cb, y, cr, y
  assign barEntry = VTPST_BARS[barIdx_q];
  always_comb begin
    case (code_q[1:0])
      VTPST_PAT_BLACK: patWord = wordCnt_q[0] ? VTPST_LUMA_BLACK :
                                                VTPST_CHROMA_BLACK;
      VTPST_PAT_LOOP:  patWord = wordCnt_q[0] ? VTPST_LUMA_LOOP :
                                                VTPST_CHROMA_LOOP;
      VTPST_PAT_EQ:    patWord = wordCnt_q[0] ? VTPST_LUMA_EQ :
                                                VTPST_CHROMA_EQ;
      default:         patWord = wordCnt_q[0] ? barEntry[29:20] :
                         (wordCnt_q[1] ? barEntry[9:0] : barEntry[19:10]);
    endcase
  end
  assign txWord = patternActive_q ? patWord : dataIn;

  // serializer: first bit leaves with the word edge, rest at period/10
  assign bitDiv = period_q / VTPST_BIT_RATIO;
  assign emit = lock_q && (parRise || (bitCnt_q != VTPST_WORD_BITS &&
                bitTimer_q == bitDiv - 8'h01));
  assign txBit   = parRise ? txWord[0] : shift_q[0];
  assign scrBit  = txBit ^ scr_q[VTPST_SCR_TAP_HI] ^ scr_q[VTPST_SCR_TAP_LO];
  assign lineBit = serialOut_q ^ scrBit;

  always_ff @(posedge clk) begin
    if (coreRst) begin
      shift_q      <= '0;
      sentWord_q   <= '0;
      bitCnt_q     <= VTPST_WORD_BITS;
      bitTimer_q   <= '0;
      scr_q        <= '0;
      serialOut_q  <= 1'b0;
      serialOutN_q <= 1'b1;
      checkWords_q <= VTPST_CRC_RESET;
    end else if (cke) begin
      if (lock_q && parRise) begin
        shift_q    <= {1'b0, txWord[9:1]};
        sentWord_q <= txWord;
        bitCnt_q   <= 4'h1;
        bitTimer_q <= '0;
      end else if (emit) begin
        shift_q    <= {1'b0, shift_q[9:1]};
        bitCnt_q   <= bitCnt_q + 4'h1;
        bitTimer_q <= '0;
      end else if (lock_q && bitCnt_q != VTPST_WORD_BITS) begin
        bitTimer_q <= bitTimer_q + 8'h01;
      end
      if (emit) begin
        scr_q        <= {scr_q[VTPST_SCR_W-2:0], scrBit};
        serialOut_q  <= lineBit;
        serialOutN_q <= ~lineBit;
        checkWords_q <= {checkWords_q[14:0], 1'b0} ^
          ((checkWords_q[15] ^ txBit) ? VTPST_CRC_POLY : VTPST_CRC_RESET);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (coreRst) serialOe_q <= 1'b0;
    else if (cke) serialOe_q <= 1'b1;
  end

  // self-check: recover own line bits and compare with the sent word
  assign rxS    = serialOut_q ^ rxPrev_q;
  assign rxD    = rxS ^ rxScr_q[VTPST_SCR_TAP_HI] ^ rxScr_q[VTPST_SCR_TAP_LO];
  assign rxWord = {rxD, rxShift_q[9:1]};
  assign errNow = checkMode_q && (!lock_q || (emitted_q &&
                  rxCnt_q == VTPST_WORD_BITS - 4'h1 &&
                  skip_q == VTPST_CHECK_SKIP && rxWord != sentWord_q));

  always_ff @(posedge clk) begin
    if (coreRst) begin
      emitted_q <= 1'b0;
      rxPrev_q  <= 1'b0;
      rxScr_q   <= '0;
      rxShift_q <= '0;
      rxCnt_q   <= '0;
      skip_q    <= '0;
      error_q   <= 1'b0;
      result_q  <= 1'b0;
    end else if (cke) begin
      emitted_q <= emit;
      if (emitted_q) begin
        rxPrev_q  <= serialOut_q;
        rxScr_q   <= {rxScr_q[VTPST_SCR_W-2:0], rxS};
        rxShift_q <= rxWord;
        if (rxCnt_q == VTPST_WORD_BITS - 4'h1) begin
          rxCnt_q <= '0;
          if (skip_q != VTPST_CHECK_SKIP) skip_q <= skip_q + 2'h1;
        end else begin
          rxCnt_q <= rxCnt_q + 4'h1;
        end
      end
      if (!checkMode_q) begin
        skip_q  <= '0;
        error_q <= 1'b0;
      end else if (errNow) begin
        error_q <= 1'b1;
      end
      result_q <= checkMode_q && fieldCnt_q == VTPST_CHECK_FIELDS &&
                  !error_q && !errNow;
    end
  end

  assign link.lockDetect      = lock_q;
  assign link.selfCheckResult = result_q;
  assign link.serialLineOut   = serialOut_q;
  assign link.serialLineOutN  = serialOutN_q;
  assign link.serialLineOe    = serialOe_q;
endmodule // vtpst_device
`default_nettype wire

// >>> logic/vtpst_ctrl.sv
// controller end: APB registers drive clock, code, enable and reset
`timescale 1ns/1ps
`default_nettype none
module vtpst_ctrl
  import vtpst_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        cke,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  vtpst_link_if.ctl        link
);
  logic [1:0]                  pinRaw;
  logic [1:0]                  pinQ;
  logic                        run_q;
  logic                        mrst_q;
  logic [VTPST_CODE_W-1:0]     codeSel_q;
  logic [7:0]                  halfDiv_q;
  logic [VTPST_PU_W-1:0]       puCnt_q;
  logic                        powerUp_q;
  logic                        clkRun;
  logic [7:0]                  divCnt_q;
  logic                        parClk_q;
  logic                        en_q;
  logic [VTPST_DATA_W-1:0]     code_q;
  logic                        access;
  logic                        mapped;
  logic [31:0]                 readMux;

  assign pinRaw = {link.selfCheckResult, link.lockDetect};
  for (genvar i = 0; i < 2; i++) begin : g_sync
    logic s1;
    logic s2;
    logic s3;
    logic q;
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        q  <= 1'b0;
      end else if (cke) begin
        s1 <= pinRaw[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) q <= s3;
      end
    end
    assign pinQ[i] = q;
  end

  // clock held off until the power-up wait has run out
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      puCnt_q   <= '0;
      powerUp_q <= 1'b0;
    end else if (cke && !powerUp_q) begin
      if (puCnt_q == VTPST_PU_W'(VTPST_POWER_UP_CYCLES - 1))
        powerUp_q <= 1'b1;
      puCnt_q <= puCnt_q + VTPST_PU_W'(1);
    end
  end

  assign clkRun = run_q & powerUp_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      divCnt_q <= '0;
      parClk_q <= 1'b0;
    end else if (cke) begin
      if (!clkRun) begin
        divCnt_q <= '0;
        parClk_q <= 1'b0;
      end else if (divCnt_q == halfDiv_q - 8'h01) begin
        divCnt_q <= '0;
        parClk_q <= ~parClk_q;
      end else begin
        divCnt_q <= divCnt_q + 8'h01;
      end
    end
  end

  // code is only changed while the enable is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_q   <= 1'b0;
      code_q <= '0;
    end else if (cke) begin
      en_q <= clkRun && pinQ[0];
      if (!en_q) code_q <= {6'h00, codeSel_q};
    end
  end

  assign access = psel & penable;
  assign mapped = (paddr == VTPST_REG_CTRL) || (paddr == VTPST_REG_DIV) ||
                  (paddr == VTPST_REG_STATUS);
  always_comb begin
    case (paddr)
      VTPST_REG_CTRL:   readMux = {24'h000000, codeSel_q, 2'h0, mrst_q, run_q};
      VTPST_REG_DIV:    readMux = {24'h000000, halfDiv_q};
      VTPST_REG_STATUS: readMux = {27'h0000000, powerUp_q, clkRun, en_q,
                                   pinQ[1], pinQ[0]};
      default:          readMux = 32'h00000000;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (cke) begin
      pready <= access & ~pready;
      if (access && !pready) begin
        pslverr <= !mapped;
        prdata  <= pwrite ? 32'h00000000 : readMux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_q     <= 1'b0;
      mrst_q    <= 1'b0;
      codeSel_q <= '0;
      halfDiv_q <= VTPST_DIV_RESET;
    end else if (cke && access && pready && pwrite) begin
      if (paddr == VTPST_REG_CTRL) begin
        run_q     <= pwdata[VTPST_CTRL_RUN];
        mrst_q    <= pwdata[VTPST_CTRL_MRST];
        codeSel_q <= pwdata[VTPST_CTRL_CODE +: VTPST_CODE_W];
      end
      if (paddr == VTPST_REG_DIV && pwdata[7:0] >= VTPST_DIV_MIN)
        halfDiv_q <= pwdata[7:0];
    end
  end

  assign link.parClk           = parClk_q;
  assign link.patternCode      = code_q;
  assign link.patternGenEnable = en_q;
  assign link.manualReset      = mrst_q;
endmodule // vtpst_ctrl
`default_nettype wire

// >>> test/vtpst_link_monitor.sv
// link checker: reset, lock, serial output and self-check result
`timescale 1ns/1ps
`default_nettype none
module vtpst_link_monitor (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       parClk,
  input wire logic [9:0] patternCode,
  input wire logic       patternGenEnable,
  input wire logic       manualReset,
  input wire logic       lockDetect,
  input wire logic       selfCheckResult,
  input wire logic       serialLineOut,
  input wire logic       serialLineOutN,
  input wire logic       serialLineOe
);
  logic [8:0] idle_q;
  logic       prev_q;
  logic       seen_q;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // cycles since the parallel clock last changed, saturating
  always_ff @(posedge clk) begin
    prev_q <= parClk;
    if (sys_rst || parClk != prev_q) idle_q <= 9'h000;
    else if (idle_q != 9'h1FF) idle_q <= idle_q + 9'h001;
  end
  // set once the parallel clock has risen since reset
  always_ff @(posedge clk) begin
    seen_q <= !sys_rst && (seen_q || (parClk && !prev_q));
  end
  chk_reset_clear: assert property ($fell(sys_rst) |->
    !serialLineOe && !lockDetect && !selfCheckResult) else $error("reset");
  chk_unlock_static: assert property (!lockDetect[*3] |->
    $stable(serialLineOut) && $stable(serialLineOutN)) else $error("toggle");
  chk_no_clock_off: assert property (!seen_q |-> !serialLineOe)
    else $error("driven early");
  chk_manual_rst: assert property (manualReset[*8] |->
    !lockDetect && !serialLineOe) else $error("manual reset");
  chk_lock_loss: assert property (idle_q > 9'h118 |-> !lockDetect)
    else $error("lock kept");
  chk_result_idle: assert property (!patternGenEnable[*8] |->
    !selfCheckResult) else $error("result while idle");
  chk_result_start: assert property ($rose(selfCheckResult) |->
    patternGenEnable && $past(patternGenEnable, 8)) else $error("early pass");
  chk_result_code: assert property (selfCheckResult |->
    patternCode[3:0] == 4'h3 || patternCode[3:0] == 4'h5) else $error("code");
  chk_enable_lock: assert property ($rose(patternGenEnable) |->
    lockDetect && patternCode[9:4] == 6'h00) else $error("enable");
endmodule // vtpst_link_monitor
`default_nettype wire

// >>> test/tb_video_test_pattern_and_self_test.sv
// bench: controller and serializer joined over the link
`timescale 1ns/1ps
`default_nettype none
module tb_video_test_pattern_and_self_test
  import vtpst_pkg::*;
;
  logic        clk;
  logic        sys_rst;
  logic        cke;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] checkWords;
  logic        patActive;
  logic [31:0] rd;
  logic        er;
  int          err_total;
  int          n_checks;
  vtpst_link_if i_vtpst_link_if ();
  vtpst_ctrl i_vtpst_ctrl (.clk(clk), .sys_rst(sys_rst), .cke(cke),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(i_vtpst_link_if.ctl));
  vtpst_device #(.NTSC_LINE_WORDS(16), .PAL_LINE_WORDS(16),
    .NTSC_FIELD_LINES(2), .PAL_FIELD_LINES(2)) i_vtpst_device (
    .clk(clk), .sys_rst(sys_rst), .cke(cke), .link(i_vtpst_link_if.dev),
    .checkWords_q(checkWords), .patternActive_q(patActive));
  vtpst_link_monitor i_vtpst_link_monitor (.clk(clk), .sys_rst(sys_rst),
    .parClk(i_vtpst_link_if.parClk),
    .patternCode(i_vtpst_link_if.patternCode),
    .patternGenEnable(i_vtpst_link_if.patternGenEnable),
    .manualReset(i_vtpst_link_if.manualReset),
    .lockDetect(i_vtpst_link_if.lockDetect),
    .selfCheckResult(i_vtpst_link_if.selfCheckResult),
    .serialLineOut(i_vtpst_link_if.serialLineOut),
    .serialLineOutN(i_vtpst_link_if.serialLineOutN),
    .serialLineOe(i_vtpst_link_if.serialLineOe));
  always #10 clk = ~clk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e, string m);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t %s", $time, m);
    end
  endtask
  // one transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    chk(n < 20, 1'b1, "apb hang");
  endtask
  task automatic wait_stat(input int b, input int lim);
    int n;
    n = 0;
    do begin
      apb(1'b0, VTPST_REG_STATUS, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < lim);
  endtask
  task automatic test_regs();
    chk(i_vtpst_link_if.serialLineOe, 1'b0, "oe");
    chk(i_vtpst_link_if.lockDetect, 1'b0, "lock");
    chk(checkWords, 16'h0000, "crc");
    apb(1'b1, VTPST_REG_DIV, 32'h3);
    apb(1'b0, VTPST_REG_DIV, 32'h0);
    chk(rd, 32'h0A, "div");
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h0, "unmapped data");
    chk(er, 1'b1, "unmapped error");
    $display("test regs done");
  endtask
  task automatic test_code(input logic [3:0] c);
    apb(1'b1, VTPST_REG_CTRL, {24'h0, c, 4'h1});
    wait_stat(0, 600);
    chk(rd[0], 1'b1, "lock");
    wait_stat(1, 500);
    chk(rd[1], c == 4'h3 || c == 4'h5, "result");
    chk(patActive, 1'b1, "pattern on");
    chk(i_vtpst_link_if.serialLineOe, 1'b1, "output");
    apb(1'b1, VTPST_REG_CTRL, {24'h0, c, 4'h0});
    repeat (300) @(posedge clk);
    chk(i_vtpst_link_if.selfCheckResult, 1'b0, "result off");
    chk(patActive, 1'b0, "pattern off");
    chk(i_vtpst_link_if.lockDetect, 1'b0, "lock off");
    $display("test code %0h done", c);
  endtask
  task automatic test_mrst();
    logic [15:0] cw;
    apb(1'b1, VTPST_REG_CTRL, 32'h31);
    wait_stat(0, 600);
    // clock enable low freezes both ends, lock and check words included
    cke <= 1'b0;
    @(posedge clk);
    cw = checkWords;
    repeat (40) @(posedge clk);
    chk(checkWords, cw, "frozen crc");
    chk(i_vtpst_link_if.lockDetect, 1'b1, "frozen lock");
    cke <= 1'b1;
    apb(1'b1, VTPST_REG_CTRL, 32'h33);
    repeat (20) @(posedge clk);
    chk(i_vtpst_link_if.lockDetect, 1'b0, "mrst lock");
    chk(i_vtpst_link_if.serialLineOe, 1'b0, "mrst oe");
    apb(1'b1, VTPST_REG_CTRL, 32'h31);
    wait_stat(0, 600);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(checkWords, 16'h0000, "crc");
    repeat (100) @(posedge clk);
    chk(i_vtpst_link_if.serialLineOe, 1'b0, "no clock");
    $display("test reset done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge clk);
    err_total++;
    conclude();
  end
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    cke = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    err_total = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    test_regs();
    for (int c = 0; c < 16; c++) test_code(c[3:0]);
    test_mrst();
    conclude();
  end
endmodule // tb_video_test_pattern_and_self_test
`default_nettype wire
